// ### verilog/pvf_regs.sv
// Purpose: output-voltage format byte and input turn-on threshold word
// Assumes: one command strobe per cycle; stored defaults offered on nv_ports
// Notes: reads answer one cycle after the strobe with registered data
//
// How it works
// RL1: format byte is read-only: 3-bit mode above a 5-bit exponent.
// RL2: writes to the format byte are refused and flag invalid data.
// RL3: format mode field reads 000, linear format.
// RL4: format exponent reads 10111 (-9); written values are ignored.
// RL5: conversion may start only when input reaches threshold and other conditions hold.
// RL6: in-range threshold writes store the nearest supported step.
// RL7: steps 4.25-9.25 by 0.25, 9.5-13 by 0.5, then 14, 15, 16 V.
// RL8: out-of-range writes keep value, set summary and invalid flags, raise alert.
// RL9: host must not write below turn-off threshold; counted as out of range.
// RL10: without a stored setting, reset value is the 4.25 V encoding.
// RL11: threshold exponent bits read 11110 (-2), writes ignored.
// RL12: mantissa is writable, reset and minimum 17, maximum 64.
// RL13: power-up threshold comes from nonvolatile storage.
// RL14: store-all command copies the threshold to nonvolatile memory.
// RL15: exact halfway values store the higher step.
`timescale 1ns/1ps
`default_nettype none
module pvf_regs
  import pvf_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic [7:0] cmd_code_in,
  input wire logic cmd_wr_in,
  input wire logic [15:0] cmd_wr_data_in,
  input wire logic cmd_rd_in,
  output logic [15:0] cmd_rd_data_out,
  output logic cmd_rd_valid_out,
  output logic cmd_unsup_out,
  input wire logic clear_faults_in,
  output logic cml_fault_out,
  output logic ivd_fault_out,
  output logic smb_alert_out,
  output logic smb_alert_oe_out,
  input wire logic [10:0] turn_off_mant_in,
  input wire logic [10:0] vin_mant_in,
  input wire logic start_ok_in,
  output logic conversion_en_out,
  input wire logic [10:0] nv_data_in,
  input wire logic nv_valid_in,
  input wire logic nv_ack_in,
  output logic nv_wr_out,
  output logic [10:0] nv_wr_data_out
);
  pvf_cmd_t kind;
  pvf_state_t state_reg;
  pvf_state_t state_next;
  logic [10:0] thr_reg;
  logic [10:0] nv_data_reg;
  logic cml_reg;
  logic ivd_reg;
  logic conv_reg;
  logic [15:0] rd_data_reg;
  logic rd_valid_reg;
  logic unsup_reg;
  logic thr_wr;
  logic thr_ok;
  logic bad_wr;
  logic store_go;

  pvf_snap_if sif ();

  pvf_cmd_decode u_decode (
    .code_in(cmd_code_in),
    .kind_out(kind)
  );

  pvf_snap u_snap (
    .sif(sif.snap)
  );

  assign sif.word = cmd_wr_data_in;
  assign thr_wr = cmd_wr_in && (kind == CMD_THR) && (state_reg != ST_RESTORE);
  assign thr_ok = sif.in_range && (sif.step >= turn_off_mant_in); // RL9
  assign bad_wr = cmd_wr_in && ((kind == CMD_FMT) || (thr_wr && !thr_ok)); // RL2 RL8
  assign store_go = cmd_wr_in && (kind == CMD_STORE) && (state_reg == ST_IDLE);

  // restore after reset, then idle; a store holds until storage acknowledges
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RESTORE:
        state_next = ST_IDLE;
      ST_IDLE:
        if (store_go)
          state_next = ST_STORE;
      ST_STORE:
        if (nv_ack_in)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
      state_reg <= ST_RESTORE;
    else
      state_reg <= state_next;
  end

  // threshold mantissa: loaded once after reset from storage, or the 4.25 V default when none is valid, then host writes
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
      thr_reg <= THR_RESET_MANT; // RL10
    else if (state_reg == ST_RESTORE)
      thr_reg <= nv_valid_in ? nv_data_in : THR_RESET_MANT; // RL13 RL10
    else if (thr_wr && thr_ok)
      thr_reg <= sif.step; // RL6 RL12
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
      nv_data_reg <= 11'h000;
    else if (store_go)
      nv_data_reg <= thr_reg; // RL14
  end

  assign nv_wr_out = (state_reg == ST_STORE); // RL14
  assign nv_wr_data_out = nv_data_reg;

  // fault flags: a new fault wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      cml_reg <= 1'b0;
      ivd_reg <= 1'b0;
    end
    else if (bad_wr)
    begin
      cml_reg <= 1'b1; // RL2 RL8
      ivd_reg <= 1'b1; // RL2 RL8
    end
    else if (clear_faults_in)
    begin
      cml_reg <= 1'b0;
      ivd_reg <= 1'b0;
    end
  end

  assign cml_fault_out = cml_reg;
  assign ivd_fault_out = ivd_reg;
  assign smb_alert_out = 1'b0;
  assign smb_alert_oe_out = cml_reg || ivd_reg; // RL8

  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
      conv_reg <= 1'b0;
    else
      conv_reg <= start_ok_in && (vin_mant_in >= thr_reg); // RL5
  end

  assign conversion_en_out = conv_reg;

  // read port: format byte is constant, threshold exponent is fixed
  always_ff @(posedge clk_sys_in)
  begin
    if (!resetn_in)
    begin
      rd_data_reg <= 16'h0000;
      rd_valid_reg <= 1'b0;
      unsup_reg <= 1'b0;
    end
    else
    begin
      rd_valid_reg <= cmd_rd_in;
      unsup_reg <= cmd_rd_in && (kind != CMD_FMT) && (kind != CMD_THR);
      if (cmd_rd_in && (kind == CMD_FMT))
        rd_data_reg <= {8'h00, FMT_MODE_LINEAR, FMT_EXPONENT}; // RL1 RL3 RL4
      else if (cmd_rd_in && (kind == CMD_THR))
        rd_data_reg <= {THR_EXPONENT, thr_reg}; // RL11
      else if (cmd_rd_in)
        rd_data_reg <= 16'h0000;
    end
  end

  assign cmd_rd_data_out = rd_data_reg;
  assign cmd_rd_valid_out = rd_valid_reg;
  assign cmd_unsup_out = unsup_reg;

  function automatic logic is_step(input logic [10:0] q);
    return ((q >= THR_MIN_MANT) && (q <= THR_FINE_TOP)) ||
           ((q > THR_FINE_TOP) && (q <= THR_MID_TOP) && !q[0]) ||
           (q == THR_STEP_56) || (q == THR_STEP_60) || (q == THR_MAX_MANT);
  endfunction

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!resetn_in);

  a_fmt_read_value: assert property ( // RL1
    cmd_rd_in && (cmd_code_in == CMD_OUT_FMT) |=> cmd_rd_valid_out && (cmd_rd_data_out == 16'h0017))
    else $error("format byte read wrong");

  a_fmt_write_refused: assert property ( // RL2
    cmd_wr_in && (cmd_code_in == CMD_OUT_FMT) |=> ivd_fault_out && cml_fault_out && smb_alert_oe_out)
    else $error("format write not flagged");

  a_fmt_mode_field: assert property ( // RL3
    cmd_rd_in && (cmd_code_in == CMD_OUT_FMT) |=> cmd_rd_data_out[7:5] == 3'h0)
    else $error("format mode not linear");

  a_bad_thr_keep: assert property ( // RL8
    thr_wr && !sif.in_range |=> $stable(thr_reg) && ivd_fault_out && smb_alert_oe_out)
    else $error("bad threshold write not refused");

  a_below_off_refused: assert property ( // RL9
    thr_wr && sif.in_range && (sif.step < turn_off_mant_in) |=> $stable(thr_reg) && cml_fault_out)
    else $error("threshold below turn-off accepted");

  a_thr_on_step: assert property ( // RL7
    thr_wr && thr_ok |=> is_step(thr_reg) && (thr_reg >= THR_MIN_MANT) && (thr_reg <= THR_MAX_MANT))
    else $error("threshold not on a supported step");

  a_thr_nearest: assert property ( // RL6
    thr_wr && thr_ok && (cmd_wr_data_in == 16'hF03B) |=> thr_reg == 11'h03C)
    else $error("nearest step not taken");

  a_thr_reset_default: assert property ( // RL10
    (state_reg == ST_RESTORE) && !nv_valid_in |=> thr_reg == 11'h011)
    else $error("reset default not 4.25 V");

  a_thr_restore_nv: assert property ( // RL13
    (state_reg == ST_RESTORE) && nv_valid_in |=> thr_reg == $past(nv_data_in))
    else $error("stored default not restored");

  a_thr_exponent: assert property ( // RL11
    cmd_rd_in && (cmd_code_in == CMD_TURN_ON) |=> cmd_rd_data_out[15:11] == 5'h1E)
    else $error("threshold exponent wrong");

  a_conv_gate: assert property ( // RL5
    conversion_en_out |-> $past(start_ok_in) && ($past(vin_mant_in) >= $past(thr_reg)))
    else $error("conversion started below threshold");

  a_store_copy: assert property ( // RL14
    store_go |=> nv_wr_out && (nv_wr_data_out == $past(thr_reg)))
    else $error("store did not copy threshold");

  a_half_up: assert property ( // RL15
    thr_wr && thr_ok && (cmd_wr_data_in == 16'hE84B) |=> thr_reg == 11'h026)
    else $error("halfway value not rounded up");

  // a fault raised in the same cycle as a clear must survive the clear
  a_set_beats_clear: assert property ( // RL2
    cmd_wr_in && (cmd_code_in == CMD_OUT_FMT) && clear_faults_in
    |=> cml_fault_out && ivd_fault_out && smb_alert_oe_out)
    else $error("fault lost to a clear in the same cycle");

  a_flags_cleared: assert property ( // RL8
    clear_faults_in && !cmd_wr_in |=> !cml_fault_out && !ivd_fault_out && !smb_alert_oe_out)
    else $error("fault flags not cleared");

  a_conv_on_reach: assert property ( // RL5
    start_ok_in && (vin_mant_in >= thr_reg) |=> conversion_en_out)
    else $error("conversion not started at threshold");

  a_conv_off_start: assert property ( // RL5
    !start_ok_in |=> !conversion_en_out)
    else $error("conversion started without start conditions");

  a_store_held: assert property ( // RL14
    nv_wr_out && !nv_ack_in |=> nv_wr_out)
    else $error("store request dropped before acknowledge");

  a_store_released: assert property ( // RL14
    nv_wr_out && nv_ack_in |=> !nv_wr_out)
    else $error("store request held after acknowledge");

  a_store_data_kept: assert property ( // RL14
    nv_wr_out && !nv_ack_in |=> $stable(nv_wr_data_out))
    else $error("store data moved during request");

  a_thr_top_kept: assert property ( // RL12
    thr_wr && (cmd_wr_data_in == 16'hF040) && (turn_off_mant_in <= 11'h040)
    |=> thr_reg == 11'h040)
    else $error("top threshold not accepted");

  a_thr_over_refused: assert property ( // RL8
    thr_wr && (cmd_wr_data_in == 16'hF041) |=> $stable(thr_reg) && ivd_fault_out)
    else $error("threshold above top accepted");

  a_thr_under_refused: assert property ( // RL7
    thr_wr && (cmd_wr_data_in == 16'hF010) |=> $stable(thr_reg) && cml_fault_out)
    else $error("threshold below bottom accepted");

  a_neg_mant_refused: assert property ( // RL12
    thr_wr && cmd_wr_data_in[10] |=> $stable(thr_reg) && ivd_fault_out)
    else $error("negative threshold accepted");

  a_coarse_tie_up: assert property ( // RL15
    thr_wr && (cmd_wr_data_in == 16'hF036) && (turn_off_mant_in <= 11'h038)
    |=> thr_reg == 11'h038)
    else $error("coarse halfway value not rounded up");
endmodule // pvf_regs
`default_nettype wire

// ### inc/pvf_pkg.sv
// Purpose: constants and types for the format and turn-on threshold registers
// Assumes: linear data format, threshold exponent fixed at -2 (0.25 V per count)
// Notes: hq_ values are in half-quarter-volt units (0.125 V)
`default_nettype none
package pvf_pkg;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;
  localparam logic [7:0] CMD_OUT_FMT = 8'h20;
  localparam logic [7:0] CMD_TURN_ON = 8'h35;
  localparam logic [2:0] FMT_MODE_LINEAR = 3'h0;
  localparam logic [4:0] FMT_EXPONENT = 5'h17;
  localparam logic [4:0] THR_EXPONENT = 5'h1E;
  localparam logic [10:0] THR_RESET_MANT = 11'h011;
  localparam logic [10:0] THR_MIN_MANT = 11'h011;
  localparam logic [10:0] THR_MAX_MANT = 11'h040;
  localparam logic [10:0] THR_FINE_TOP = 11'h025;
  localparam logic [10:0] THR_MID_TOP = 11'h034;
  localparam logic [10:0] THR_STEP_56 = 11'h038;
  localparam logic [10:0] THR_STEP_60 = 11'h03C;
  // linear value to half-quarter units: shift by exponent + 3
  localparam int HQ_SHIFT = 3;
  localparam int HQ_MAX_SHIFT = 7;
  localparam logic [17:0] HQ_LOW = 18'h00022;
  localparam logic [17:0] HQ_MID = 18'h0004C;
  localparam logic [17:0] HQ_COARSE = 18'h00068;
  localparam logic [17:0] HQ_HALF_54 = 18'h0006C;
  localparam logic [17:0] HQ_HALF_58 = 18'h00074;
  localparam logic [17:0] HQ_HALF_62 = 18'h0007C;
  localparam logic [17:0] HQ_TOP = 18'h00080;
  typedef enum logic [1:0] {ST_RESTORE = 2'h0, ST_IDLE = 2'h1, ST_STORE = 2'h3} pvf_state_t;
  typedef enum logic [1:0] {CMD_NONE, CMD_FMT, CMD_THR, CMD_STORE} pvf_cmd_t;
endpackage
`default_nettype wire

// ### inc/pvf_snap_if.sv
// Purpose: carries a written threshold word to the step snapper and back
// Assumes: purely combinational path
// Notes: step is valid only while in_range is high
`timescale 1ns/1ps
`default_nettype none
interface pvf_snap_if;
  logic [15:0] word;
  logic [10:0] step;
  logic in_range;
  modport src (output word, input step, input in_range);
  modport snap (input word, output step, output in_range);
endinterface
`default_nettype wire

// ### verilog/pvf_snap.sv
// Purpose: maps a linear-format voltage onto the nearest supported turn-on step
// Assumes: word is exponent [15:11] and mantissa [10:0], both two's complement
// Notes: discarded low bits only decide in_range at the top of the range
`timescale 1ns/1ps
`default_nettype none
module pvf_snap
  import pvf_pkg::*;
(
  pvf_snap_if.snap sif
);
  int sh;
  logic [10:0] mant;
  logic [17:0] hq;
  logic lost;
  logic over;

  always_comb
  begin
    mant = sif.word[10:0];
    sh = int'($signed(sif.word[15:11])) + HQ_SHIFT;
    hq = 18'h00000;
    lost = 1'b0;
    over = 1'b0;
    if (sh > HQ_MAX_SHIFT)
    begin
      over = (mant != 11'h000);
    end
    else if (sh >= 0)
    begin
      hq = 18'({7'h00, mant} << sh);
    end
    else
    begin
      hq = 18'({7'h00, mant} >> (-sh));
      lost = ((int'(mant) & ((1 << (-sh)) - 1)) != 0);
    end
  end

  always_comb
  begin
    sif.in_range = !mant[10] && !over && (hq >= HQ_LOW) &&
                   ((hq < HQ_TOP) || ((hq == HQ_TOP) && !lost));
    // ties round up to the higher step
    if (hq < HQ_MID) // RL6 RL15
      sif.step = 11'((hq + 18'h00001) >> 1);
    else if (hq < HQ_COARSE) // RL7 RL15
      sif.step = 11'(((hq + 18'h00002) >> 2) << 1);
    else if (hq < HQ_HALF_54)
      sif.step = THR_MID_TOP;
    else if (hq < HQ_HALF_58)
      sif.step = THR_STEP_56;
    else if (hq < HQ_HALF_62)
      sif.step = THR_STEP_60;
    else
      sif.step = THR_MAX_MANT;
  end
endmodule // pvf_snap
`default_nettype wire

// ### verilog/pvf_cmd_decode.sv
// Purpose: classifies a command code into the commands this block answers
// Assumes: code is stable while a strobe is high
// Notes: anything else decodes as none
`timescale 1ns/1ps
`default_nettype none
module pvf_cmd_decode
  import pvf_pkg::*;
(
  input wire logic [7:0] code_in,
  output pvf_cmd_t kind_out
);
  function automatic pvf_cmd_t classify(input logic [7:0] code);
    if (code == CMD_OUT_FMT)
      return CMD_FMT;
    else if (code == CMD_TURN_ON)
      return CMD_THR;
    else if (code == CMD_STORE_ALL)
      return CMD_STORE;
    else
      return CMD_NONE;
  endfunction

  assign kind_out = classify(code_in);
endmodule // pvf_cmd_decode
`default_nettype wire

// ### bench/pvf_host.sv
// Purpose: host and storage stand-in for the register bank
// Assumes: strobes move 1 ns after a rising edge
// Notes: storage acks after three cycles of request
`timescale 1ns/1ps
`default_nettype none
module pvf_host (
  input wire logic clk_in,
  input wire logic nv_wr_in,
  input wire logic [10:0] nv_wr_data_in,
  output logic [7:0] code_out,
  output logic wr_out,
  output logic rd_out,
  output logic [15:0] data_out,
  output logic nv_ack_out,
  output logic [10:0] nv_mem_out
);
  int wait_cnt = 0;
  initial
  begin
    code_out = 8'h00;
    wr_out = 1'h0;
    rd_out = 1'h0;
    data_out = 16'h0000;
    nv_ack_out = 1'h0;
    nv_mem_out = 11'h000;
  end
  // one strobe held across exactly one sampling edge
  task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    code_out = c;
    wr_out = w;
    rd_out = !w;
    data_out = d;
    @(posedge clk_in);
    #1;
    wr_out = 1'h0;
    rd_out = 1'h0;
    data_out = ~d;
  endtask
  always @(posedge clk_in)
  begin
    wait_cnt <= nv_wr_in ? wait_cnt + 1 : 0;
    nv_ack_out <= #1 nv_wr_in && wait_cnt == 2;
    if (nv_ack_out && nv_wr_in)
      nv_mem_out <= nv_wr_data_in;
  end
endmodule // pvf_host
`default_nettype wire

// ### bench/tb_pvf_regs.sv
// Purpose: self-checking bench for the format and turn-on registers
// Assumes: reads answer one cycle after the strobe
// Notes: a read queue is checked by a watcher process
`timescale 1ns/1ps
`default_nettype none
module tb_pvf_regs import pvf_pkg::*;;
  logic clk_sys_in = 1'h0, resetn_in = 1'h0, clear_faults_in = 1'h0;
  logic start_ok_in = 1'h0, nv_valid_in = 1'h0;
  logic cmd_wr_in, cmd_rd_in, cmd_rd_valid_out, cmd_unsup_out, cml_fault_out;
  logic ivd_fault_out, smb_alert_out, smb_alert_oe_out, conversion_en_out;
  logic nv_ack_in, nv_wr_out;
  logic [7:0] cmd_code_in;
  logic [15:0] cmd_wr_data_in, cmd_rd_data_out;
  logic [10:0] turn_off_mant_in = 11'h010, vin_mant_in = 11'h000;
  logic [10:0] nv_data_in = 11'h000, nv_wr_data_out, nv_mem, cur;
  logic [16:0] expq[$];
  logic [15:0] tw[12] = '{16'hF011, 16'hE84B, 16'hF036, 16'hF029, 16'h000C, 16'hF040,
    16'hF041, 16'hF010, 16'hF7FF, 16'hF03B, 16'hF014, 16'hF020};
  // zero marks a refused write
  logic [10:0] te[12] = '{11'h011, 11'h026, 11'h038, 11'h02A, 11'h030, 11'h040,
    11'h000, 11'h000, 11'h000, 11'h03C, 11'h000, 11'h020};
  int fails = 0, n_compared = 0, cyc = 0;
  logic [31:0] seed = 32'h76EBF1B4;
  pvf_regs dut (.clk_sys_in, .resetn_in, .cmd_code_in, .cmd_wr_in, .cmd_wr_data_in,
    .cmd_rd_in, .cmd_rd_data_out, .cmd_rd_valid_out, .cmd_unsup_out, .clear_faults_in,
    .cml_fault_out, .ivd_fault_out, .smb_alert_out, .smb_alert_oe_out, .turn_off_mant_in,
    .vin_mant_in, .start_ok_in, .conversion_en_out, .nv_data_in, .nv_valid_in,
    .nv_ack_in, .nv_wr_out, .nv_wr_data_out);
  pvf_host host (.clk_in(clk_sys_in), .nv_wr_in(nv_wr_out), .nv_wr_data_in(nv_wr_data_out),
    .code_out(cmd_code_in), .wr_out(cmd_wr_in), .rd_out(cmd_rd_in),
    .data_out(cmd_wr_data_in), .nv_ack_out(nv_ack_in), .nv_mem_out(nv_mem));
  always #2 clk_sys_in = ~clk_sys_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [16:0] e, input logic [16:0] g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [16:0] e);
    expq.push_back(e);
    host.cmd(c, 1'h0, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    host.cmd(c, 1'h1, d);
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic flags(input logic r);
    chk({13'h0000, {3{r}}, 1'h0},
      {13'h0000, cml_fault_out, ivd_fault_out, smb_alert_oe_out, smb_alert_out});
    clear_faults_in = 1'h1;
    @(posedge clk_sys_in);
    #1;
    clear_faults_in = 1'h0;
  endtask
  task automatic rst(input logic v, input logic [10:0] d);
    resetn_in = 1'h0;
    nv_valid_in = v;
    nv_data_in = d;
    repeat (6) @(posedge clk_sys_in);
    #1;
    resetn_in = 1'h1;
    repeat (2) @(posedge clk_sys_in);
    #1;
    nv_data_in = ~d;
  endtask
  // read answers: unsupported flag above the data word
  always @(negedge clk_sys_in)
    if (cmd_rd_valid_out === 1'h1)
      chk(expq.pop_front(), {cmd_unsup_out, cmd_rd_data_out});
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      fails = fails + 1;
      stop_test();
    end
  end
  initial
  begin
    rst(1'h0, 11'h055);
    rd(CMD_TURN_ON, 17'h0F011);
    rd(CMD_OUT_FMT, 17'h00017);
    wr(CMD_OUT_FMT, 16'hFFFF);
    flags(1'h1);
    rd(CMD_OUT_FMT, 17'h00017);
    clear_faults_in = 1'h1;
    host.cmd(CMD_OUT_FMT, 1'h1, 16'h0017);
    clear_faults_in = 1'h0;
    @(posedge clk_sys_in);
    #1;
    flags(1'h1);
    rd(8'h99, 17'h10000);
    cur = 11'h011;
    for (int i = 0; i < 12; i++)
    begin
      turn_off_mant_in = (i > 9) ? 11'h020 : 11'h010;
      wr(CMD_TURN_ON, tw[i]);
      if (te[i] !== 11'h000)
        cur = te[i];
      flags(te[i] === 11'h000);
      rd(CMD_TURN_ON, {1'h0, 5'h1E, cur});
    end
    turn_off_mant_in = 11'h010;
    repeat (8)
    begin
      seed = lfsr(seed);
      cur = 11'h011 + 11'(seed[7:0] % 21);
      wr(CMD_TURN_ON, {5'h1E, cur});
      rd(CMD_TURN_ON, {1'h0, 5'h1E, cur});
      vin_mant_in = cur + 11'(seed[9:8]) - 11'h001;
      start_ok_in = seed[10];
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk({16'h0000, start_ok_in && vin_mant_in >= cur}, {16'h0000, conversion_en_out});
    end
    wr(CMD_STORE_ALL, 16'h0000);
    chk({1'h1, 5'h00, cur}, {nv_wr_out, 5'h00, nv_wr_data_out});
    repeat (6) @(posedge clk_sys_in);
    #1;
    chk(17'h00000, {16'h0000, nv_wr_out});
    rst(1'h1, nv_mem);
    rd(CMD_TURN_ON, {1'h0, 5'h1E, cur});
    repeat (4) @(posedge clk_sys_in);
    stop_test();
  end
endmodule // tb_pvf_regs
`default_nettype wire
